/* pkg/bcs_defs.vh */
// Purpose: constants of the battery charge sequencer
// Assumes: 10 MHz clock, thermal code LSB is 0.1 mV
// Notes:   cycle counts are derived inside the module
//
// How it works
// - new cycle on power-up or falling max crossing
// - fast charge only when voltage and temperature valid
// - otherwise pulse-trickle (trickle variant only) until voltage and temperature valid
// - 19 s samples, stop on 25.6 mV fall
// - slope test only inside cutoff/low-fault window
// - sample: 15 conversions over 16 plus the 16th over 4096, 57 us apart
// - thermal cutoff terminates charging any time
// - over max cell voltage ends fast/top-off
// - plain variant timeouts 440/110/55 minutes
// - trickle variant timeouts 320/80/40 minutes
// - timer limits fast, restarts for top-off
// - top-off follows fast at low or mid, trickle variant only
// - top-off pulses 286 us on, 4290 us off
// - top-off ends on voltage, timer, cutoff only
// - trickle 286 us per 72.9 or 17.9 ms
// - indicator low in fast and pending states
// - hold freezes fast, top-off and timer
// - hold freezes the indicator value
// - hold keeps temperature checks and trickle pulses
// - hold clears the thermal sample history
// - above power-down: low power, both pins released
// - back below power-down: pulse-trickle (idle in plain variant) until new cycle
// - switch released passes current, low blocks it
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

`define BCS_CLK_MHZ      10
`define BCS_US_PER_S     1000000
`define BCS_SEC_PER_MIN  16'h003C
`define BCS_ON_US        286
`define BCS_TOP_OFF_US   4290
`define BCS_TRK_SLOW_US  72900
`define BCS_TRK_FAST_US  17900
`define BCS_CONV_US      57
`define BCS_NCONV_LOG2   4
`define BCS_SLOPE_S      5'h13
`define BCS_DROP_CODE    17'h00100
`define BCS_TMO_D_MID    16'h01B8
`define BCS_TMO_D_LOW    16'h006E
`define BCS_TMO_D_HIGH   16'h0037
`define BCS_TMO_T_MID    16'h0140
`define BCS_TMO_T_LOW    16'h0050
`define BCS_TMO_T_HIGH   16'h0028
`define BCS_TM_LOW       2'h0
`define BCS_TM_MID       2'h1
`define BCS_TM_HIGH      2'h2
`define BCS_ST_START     3'h0
`define BCS_ST_PEND      3'h1
`define BCS_ST_FAST      3'h2
`define BCS_ST_TOPOFF    3'h3
`define BCS_ST_TRICKLE   3'h4
`define BCS_ST_IDLE      3'h5
`define BCS_ST_LOWPWR    3'h6

`endif

/* src/bcs_charge_sequencer.v */
// Purpose: charge sequencing for a nickel cell charger
// Assumes: threshold flags and thermal code come from an
//          external converter, asynchronous to clk_in
// Notes:   open-drain pins drive low while their _oe is high
`timescale 1ns/100ps
`default_nettype none
`include "bcs_defs.vh"

module bcs_charge_sequencer #(
    parameter [19:0] TOP_OFF_CYC  = `BCS_TOP_OFF_US * `BCS_CLK_MHZ,
    parameter [19:0] TRK_SLOW_CYC = `BCS_TRK_SLOW_US * `BCS_CLK_MHZ,
    parameter [19:0] TRK_FAST_CYC = `BCS_TRK_FAST_US * `BCS_CLK_MHZ,
    parameter [23:0] SEC_CYC      = `BCS_US_PER_S * `BCS_CLK_MHZ
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        trickle_variant_in,
    input  wire [1:0]  timer_select_in,
    input  wire        charge_hold_in,
    input  wire        cell_above_max_in,
    input  wire        cell_above_pd_in,
    input  wire        thermal_below_cutoff_in,
    input  wire        thermal_below_htf_in,
    input  wire        thermal_above_ltf_in,
    input  wire [15:0] thermal_code_in,
    output wire        charge_switch_out,
    output wire        charge_switch_oe_out,
    output wire        status_indicator_out,
    output wire        status_indicator_oe_out,
    output wire [2:0]  charge_state_out
);

    localparam [11:0] ON_CYC   = `BCS_ON_US * `BCS_CLK_MHZ;
    localparam [9:0]  CONV_CYC = `BCS_CONV_US * `BCS_CLK_MHZ;

    // two-stage synchroniser for every pin input except rst_n_in
    // left out of reset on purpose: the pins fill both stages while
    // reset is held, so the start decision on the first edge after
    // release sees the real pins and not a cleared, all-valid pattern
    reg  [24:0] meta_ff;
    reg  [24:0] sync_ff;
    wire [24:0] raw_in = {trickle_variant_in, timer_select_in,
                          charge_hold_in, cell_above_max_in,
                          cell_above_pd_in, thermal_below_cutoff_in,
                          thermal_below_htf_in, thermal_above_ltf_in,
                          thermal_code_in};

    // one pair of flops per pin bit; only the second stage is read
    genvar si;
    generate
        for (si = 0; si < 25; si = si + 1) begin : g_sync
            always @(posedge clk_in) begin
                meta_ff[si] <= raw_in[si];
                sync_ff[si] <= meta_ff[si];
            end
        end
    endgenerate

    wire        s_var  = sync_ff[24];
    wire [1:0]  s_tm   = sync_ff[23:22];
    wire        s_hold = sync_ff[21];
    wire        s_max  = sync_ff[20];
    wire        s_pd   = sync_ff[19];
    wire        s_cut  = sync_ff[18];
    wire        s_htf  = sync_ff[17];
    wire        s_ltf  = sync_ff[16];
    wire [15:0] s_code = sync_ff[15:0];

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg         max_d_ff;
    reg         hold_d_ff;
    reg  [23:0] pre_ff;
    reg  [15:0] sec_cnt_ff;
    reg  [4:0]  slope_s_ff;
    reg         conv_busy_ff;
    reg  [3:0]  conv_idx_ff;
    reg  [9:0]  conv_gap_ff;
    reg  [19:0] acc_ff;
    reg         smp_done_ff;
    reg  [15:0] avg_ff;
    reg  [1:0]  hist_cnt_ff;
    reg  [15:0] hist_ff [0:2];
    reg         pwm_on_ff;
    reg  [19:0] pwm_cnt_ff;
    reg         sw_oe_ff;
    reg         led_oe_ff;
    reg  [15:0] limit_min;
    reg         chg_en;

    // edge detectors on synchronised levels
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            max_d_ff  <= 1'b0;
            hold_d_ff <= 1'b0;
        end else begin
            max_d_ff  <= s_max;
            hold_d_ff <= s_hold;
        end
    end

    wire cyc_start = max_d_ff & ~s_max;
    wire hold_rise = s_hold & ~hold_d_ff;
    wire in_fast   = (state_ff == `BCS_ST_FAST);
    wire in_top    = (state_ff == `BCS_ST_TOPOFF);
    wire active    = (in_fast | in_top) & ~s_hold;

    // start window: voltage and temperature both valid
    wire temp_ok  = ~s_htf & (~s_var | ~s_ltf);
    wire start_ok = temp_ok & ~s_max;
    // slope test window
    wire slope_win = ~s_cut & (~s_var | ~s_ltf);

    // safety timer limit from decoded select level
    always @* begin
        case (s_tm)
            `BCS_TM_LOW:
                limit_min = s_var ? `BCS_TMO_T_LOW : `BCS_TMO_D_LOW;
            `BCS_TM_HIGH:
                limit_min = s_var ? `BCS_TMO_T_HIGH : `BCS_TMO_D_HIGH;
            default:
                limit_min = s_var ? `BCS_TMO_T_MID : `BCS_TMO_D_MID;
        endcase
    end

    wire [31:0] limit_s = limit_min * `BCS_SEC_PER_MIN;
    wire        tmo_hit = ({16'h0000, sec_cnt_ff} >= limit_s);

    // fall of 25.6 mV or more against three samples back
    wire [16:0] avg_plus   = {1'b0, avg_ff} + `BCS_DROP_CODE;
    wire        slope_trip = smp_done_ff & (hist_cnt_ff == 2'h3) & slope_win &
                             ({1'b0, hist_ff[2]} >= avg_plus);

    wire top_sel = s_var & (s_tm != `BCS_TM_HIGH);
    wire [2:0] end_state = top_sel ? `BCS_ST_TOPOFF :
                           (s_var ? `BCS_ST_TRICKLE : `BCS_ST_IDLE);

    // charge phase sequencing
    // low power overrides every state; cutoff and max voltage end
    // charging even in hold, while the timer and slope tests wait
    // until hold is gone
    always @* begin
        nxt_state = state_ff;
        if (s_pd) begin
            nxt_state = `BCS_ST_LOWPWR;
        end else begin
            case (state_ff)
                `BCS_ST_LOWPWR: begin
                    nxt_state = s_var ? `BCS_ST_TRICKLE : `BCS_ST_IDLE;
                end
                `BCS_ST_START: begin
                    nxt_state = start_ok ? `BCS_ST_FAST : `BCS_ST_PEND;
                end
                `BCS_ST_PEND: begin
                    if (cyc_start)
                        nxt_state = `BCS_ST_START;
                    else if (start_ok)
                        nxt_state = `BCS_ST_FAST;
                end
                `BCS_ST_FAST: begin
                    if (s_cut)
                        nxt_state = end_state;
                    else if (s_max)
                        nxt_state = end_state;
                    else if (slope_trip)
                        nxt_state = end_state;
                    else if (!s_hold && tmo_hit)
                        nxt_state = end_state;
                end
                `BCS_ST_TOPOFF: begin
                    if (s_cut || s_max || (!s_hold && tmo_hit))
                        nxt_state = `BCS_ST_TRICKLE;
                end
                `BCS_ST_TRICKLE, `BCS_ST_IDLE: begin
                    if (cyc_start)
                        nxt_state = `BCS_ST_START;
                end
                default: nxt_state = `BCS_ST_START;
            endcase
        end
    end

    // power-up lands in START, which begins a cycle
    always @(posedge clk_in) begin
        if (!rst_n_in)
            state_ff <= `BCS_ST_START;
        else
            state_ff <= nxt_state;
    end

    // timer restarts on entry to fast charge or top-off
    wire enter_chg = (nxt_state != state_ff) &&
                     (nxt_state == `BCS_ST_FAST || nxt_state == `BCS_ST_TOPOFF);
    wire sec_tick  = (pre_ff == SEC_CYC - 24'h000001);

    // safety timer in seconds, frozen in hold
    // the prescaler is frozen too, so a resumed phase keeps the
    // fraction of a second it had already run
    always @(posedge clk_in) begin
        if (!rst_n_in || enter_chg) begin
            pre_ff     <= 24'h000000;
            sec_cnt_ff <= 16'h0000;
        end else if (active) begin
            pre_ff <= sec_tick ? 24'h000000 : pre_ff + 24'h000001;
            if (sec_tick)
                sec_cnt_ff <= sec_cnt_ff + 16'h0001;
        end
    end

    wire fast_run  = in_fast & ~s_hold;
    wire hist_clr  = hold_rise | (enter_chg & (nxt_state == `BCS_ST_FAST));
    wire smp_start = fast_run & sec_tick & (slope_s_ff == `BCS_SLOPE_S - 5'h01);
    wire conv_take = conv_busy_ff & (conv_gap_ff == CONV_CYC - 10'h001);

    // sample period counter and 16-conversion averaging burst
    always @(posedge clk_in) begin
        if (!rst_n_in || hist_clr || !fast_run) begin
            slope_s_ff   <= 5'h00;
            conv_busy_ff <= 1'b0;
            conv_idx_ff  <= 4'h0;
            conv_gap_ff  <= 10'h000;
            acc_ff       <= 20'h00000;
            smp_done_ff  <= 1'b0;
        end else begin
            smp_done_ff <= 1'b0;
            if (sec_tick)
                slope_s_ff <= smp_start ? 5'h00 : slope_s_ff + 5'h01;
            if (smp_start && !conv_busy_ff) begin
                conv_busy_ff <= 1'b1;
                conv_idx_ff  <= 4'h0;
                conv_gap_ff  <= 10'h000;
                acc_ff       <= 20'h00000;
            end else if (conv_busy_ff) begin
                conv_gap_ff <= conv_take ? 10'h000 : conv_gap_ff + 10'h001;
                if (conv_take) begin
                    acc_ff      <= acc_ff + {4'h0, s_code};
                    conv_idx_ff <= conv_idx_ff + 4'h1;
                    if (conv_idx_ff == 4'hF) begin
                        conv_busy_ff <= 1'b0;
                        smp_done_ff  <= 1'b1;
                    end
                end
            end
        end
    end

    // average of the finished burst
    // the last code is added here as s_code[15:12] only, so the latched
    // value is the first 15 codes over 16 plus the last code over 4096
    always @(posedge clk_in) begin
        if (!rst_n_in)
            avg_ff <= 16'h0000;
        else if (conv_take && conv_idx_ff == 4'hF)
            avg_ff <= acc_ff[19:4] + {12'h000, s_code[15:12]};
    end

    // count of valid history entries
    always @(posedge clk_in) begin
        if (!rst_n_in || hist_clr)
            hist_cnt_ff <= 2'h0;
        else if (smp_done_ff && hist_cnt_ff != 2'h3)
            hist_cnt_ff <= hist_cnt_ff + 2'h1;
    end

    // three-deep sample history, newest at entry 0
    // entry 2 is the sample taken three periods before the new one
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_hist
            always @(posedge clk_in) begin
                if (!rst_n_in || hist_clr)
                    hist_ff[gi] <= 16'h0000;
                else if (smp_done_ff)
                    hist_ff[gi] <= (gi == 0) ? avg_ff : hist_ff[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    // pulse modulation: top-off or trickle off-time
    // the counter runs free; a new off-time applies from the
    // current phase onward, so no pulse is ever cut short
    wire        pwm_top = in_top & ~s_hold;
    wire [19:0] off_len = pwm_top ? TOP_OFF_CYC :
                          ((s_tm == `BCS_TM_MID) ? TRK_FAST_CYC : TRK_SLOW_CYC);
    wire        on_end  = pwm_on_ff & (pwm_cnt_ff == {8'h00, ON_CYC} - 20'h00001);
    wire        off_end = ~pwm_on_ff & (pwm_cnt_ff >= off_len - 20'h00001);

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            pwm_on_ff  <= 1'b0;
            pwm_cnt_ff <= 20'h00000;
        end else if (on_end || off_end) begin
            pwm_on_ff  <= ~pwm_on_ff;
            pwm_cnt_ff <= 20'h00000;
        end else begin
            pwm_cnt_ff <= pwm_cnt_ff + 20'h00001;
        end
    end

    // current enable per state
    // decoded from the next state, so the registered pin changes in
    // the same edge as the state and fast charge never starts with
    // one blocked cycle or ends with one released cycle
    always @* begin
        case (nxt_state)
            `BCS_ST_FAST:
                chg_en = s_hold ? (s_var & pwm_on_ff) : 1'b1;
            `BCS_ST_TOPOFF:
                chg_en = s_hold ? (s_var & pwm_on_ff) : pwm_on_ff;
            `BCS_ST_PEND, `BCS_ST_TRICKLE:
                chg_en = s_var & pwm_on_ff;
            default:
                chg_en = 1'b0;
        endcase
    end

    // open-drain drives; low blocks current, released passes it
    // both enables are registered so the pins never glitch while
    // the next-state logic settles
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sw_oe_ff  <= 1'b1;
            led_oe_ff <= 1'b0;
        end else begin
            sw_oe_ff <= (nxt_state == `BCS_ST_LOWPWR) ? 1'b0 : ~chg_en;
            if (nxt_state == `BCS_ST_LOWPWR)
                led_oe_ff <= 1'b0;
            else if (!s_hold)
                led_oe_ff <= (nxt_state == `BCS_ST_FAST) ||
                             (nxt_state == `BCS_ST_PEND);
        end
    end

    assign charge_switch_out       = 1'b0;
    assign charge_switch_oe_out    = sw_oe_ff;
    assign status_indicator_out    = 1'b0;
    assign status_indicator_oe_out = led_oe_ff;
    assign charge_state_out        = state_ff;

endmodule // bcs_charge_sequencer
`default_nettype wire

/* tb/bcs_charge_sequencer_tb_top.sv */
// Purpose: self-checking bench of the charge sequencer
// Assumes: short second and off-time counts; the on-time stays 2860 cycles
// Notes:   a small state model gives the state expected after fast charge and at cycle start
`timescale 1ns/100ps
`default_nettype none
`include "bcs_defs.vh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0d got %0d", nm, e, s); end end
module bcs_charge_sequencer_tb_top;
    localparam int SEC = 10, TOF = 30, TSL = 60, TFA = 40, T40 = 40 * 60 * SEC;
    logic rst_n = 1'b0, vr = 1'b1, hold = 1'b0, mx = 1'b0, pd = 1'b0, cut = 1'b0;
    logic clk_in = 1'b0, htf = 1'b0, ltf = 1'b0;
    logic [1:0] tm = `BCS_TM_LOW;
    logic [15:0] code = 16'h0000;
    logic [3:0] sv[5] = '{4'hC, 4'hA, 4'h9, 4'h2, 4'h8};
    int off_t[3] = '{TSL, TFA, TSL};
    wire sw, sw_oe, ind, ind_oe, cur, lit;
    wire [2:0] state;
    int pc, n, p0, on_c, off_c, err_total = 0, check_count = 0, seed = 70539;
    bcs_charge_sequencer #(.TOP_OFF_CYC(TOF), .TRK_SLOW_CYC(TSL), .TRK_FAST_CYC(TFA),
        .SEC_CYC(SEC)) u_bcs_charge_sequencer (
        .clk_in(clk_in), .rst_n_in(rst_n), .trickle_variant_in(vr), .timer_select_in(tm),
        .charge_hold_in(hold), .cell_above_max_in(mx), .cell_above_pd_in(pd),
        .thermal_below_cutoff_in(cut), .thermal_below_htf_in(htf),
        .thermal_above_ltf_in(ltf), .thermal_code_in(code), .charge_switch_out(sw),
        .charge_switch_oe_out(sw_oe), .status_indicator_out(ind),
        .status_indicator_oe_out(ind_oe), .charge_state_out(state));
    bcs_pack_model u_bcs_pack_model (.clk_in(clk_in), .switch_in(sw), .switch_oe_in(sw_oe),
        .indicator_in(ind), .indicator_oe_in(ind_oe), .current_on_out(cur),
        .lamp_lit_out(lit), .pulse_count_out(pc));
    // 10 MHz clock
    initial forever #50 clk_in = ~clk_in;
    // state after fast charge ends, and state chosen at cycle start
    function automatic int after_fast(input logic v, input logic [1:0] t);
        return !v ? `BCS_ST_IDLE : t == `BCS_TM_HIGH ? `BCS_ST_TRICKLE : `BCS_ST_TOPOFF;
    endfunction
    function automatic int at_start(input logic [3:0] s);
        return s[2] || s[0] || (s[3] && s[1]) ? `BCS_ST_PEND : `BCS_ST_FAST;
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
    endtask
    // let a pin change cross the synchroniser, then compare the state
    task automatic sc(input int e);
        step(5);
        @(negedge clk_in);
        `CHK("state", e[2:0], state)
    endtask
    // power application with the start inputs {variant, hot, cold, max}
    task automatic por(input logic [3:0] s);
        @(posedge clk_in);
        rst_n <= 1'b0;
        {vr, htf, ltf, mx} <= s;
        {hold, pd, cut} <= 3'h0;
        step(20);
        rst_n <= 1'b1;
    endtask
    // count cycles until the current line shows the given level
    task automatic upto(input logic lv, inout int c);
        c = 0;
        while (cur !== lv && c < 9000) begin
            @(negedge clk_in);
            c++;
        end
    endtask
    // align on a fresh current pulse and measure its on and off lengths
    task automatic pw(input int off_e);
        upto(1'b0, n);
        upto(1'b1, n);
        upto(1'b0, on_c);
        upto(1'b1, off_c);
        `CHK("on cycles", 2860, on_c)
        `CHK("off cycles", off_e, off_c)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        step(90000);
        err_total++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        por(4'h8);
        @(posedge clk_in) code <= 16'($random(seed));
        sc(`BCS_ST_FAST);
        `CHK("current", 1'b1, cur)
        `CHK("lamp", 1'b1, lit)
        $display("done: power-on");
        @(posedge clk_in) hold <= 1'b1;
        p0 = pc;
        step(3100);
        sc(`BCS_ST_FAST);
        `CHK("lamp", 1'b1, lit)
        `CHK("pulses", 1'b1, pc > p0)
        @(posedge clk_in) cut <= 1'b1;
        sc(`BCS_ST_TRICKLE);
        `CHK("lamp", 1'b1, lit)
        @(posedge clk_in) hold <= 1'b0;
        sc(`BCS_ST_TRICKLE);
        `CHK("lamp", 1'b0, lit)
        @(posedge clk_in) cut <= 1'b0;
        @(posedge clk_in) mx <= 1'b1;
        sc(`BCS_ST_TRICKLE);
        @(posedge clk_in) mx <= 1'b0;
        sc(`BCS_ST_FAST);
        $display("done: hold and new cycle");
        @(posedge clk_in) mx <= 1'b1;
        @(posedge clk_in) mx <= 1'b0;
        sc(after_fast(vr, tm));
        pw(TOF);
        @(posedge clk_in) mx <= 1'b1;
        sc(`BCS_ST_TRICKLE);
        pw(off_t[tm]);
        @(posedge clk_in) tm <= `BCS_TM_MID;
        pw(off_t[`BCS_TM_MID]);
        $display("done: top-off and trickle");
        for (int i = 0; i < 5; i++) begin
            por(sv[i]);
            sc(at_start(sv[i]));
            `CHK("lamp", 1'b1, lit)
            @(posedge clk_in) {htf, ltf, mx} <= 3'h0;
            sc(`BCS_ST_FAST);
        end
        $display("done: start window");
        for (int v = 0; v < 2; v++) begin
            por({v[0], 3'h0});
            @(posedge clk_in) pd <= 1'b1;
            sc(`BCS_ST_LOWPWR);
            `CHK("current", 1'b1, cur)
            @(posedge clk_in) pd <= 1'b0;
            sc(v ? `BCS_ST_TRICKLE : `BCS_ST_IDLE);
        end
        por(4'h0);
        @(posedge clk_in) mx <= 1'b1;
        sc(after_fast(1'b0, tm));
        `CHK("current", 1'b0, cur)
        $display("done: low power and plain variant");
        @(posedge clk_in) tm <= `BCS_TM_HIGH;
        por(4'h8);
        sc(`BCS_ST_FAST);
        n = 0;
        while (state === `BCS_ST_FAST && n < 30000) begin
            @(negedge clk_in);
            n++;
        end
        `CHK("timeout", 1'b1, n > T40 - 20 && n < T40 + 5)
        sc(after_fast(1'b1, tm));
        $display("done: safety timer");
        tally_and_finish();
    end
endmodule // bcs_charge_sequencer_tb_top
`default_nettype wire

/* tb/bcs_pack_model.sv */
// Purpose: supply switch and pack behind the two open-drain lines
// Assumes: both lines are pulled up
// Notes:   counts current pulses reaching the pack
`timescale 1ns/100ps
`default_nettype none
module bcs_pack_model (
    input  wire logic clk_in,
    input  wire logic switch_in,
    input  wire logic switch_oe_in,
    input  wire logic indicator_in,
    input  wire logic indicator_oe_in,
    output var  logic current_on_out,
    output var  logic lamp_lit_out,
    output var  int   pulse_count_out
);
    logic prev_ff = 1'b0;
    // a released line floats high and lets current flow
    always_comb current_on_out = switch_oe_in ? switch_in : 1'b1;
    always_comb lamp_lit_out = indicator_oe_in && !indicator_in;
    initial pulse_count_out = 0;
    // count each start of current flow
    always @(posedge clk_in) begin
        prev_ff <= current_on_out;
        if (current_on_out && !prev_ff)
            pulse_count_out <= pulse_count_out + 1;
    end
endmodule // bcs_pack_model
`default_nettype wire

/* tb/bcs_seq_assertions.sv */
// Purpose: pin checks of the charge sequencer
// Assumes: pins reach the logic through two flops
// Notes:   shift registers qualify input history
`timescale 1ns/100ps
`default_nettype none
`include "bcs_defs.vh"
module bcs_seq_assertions (
    input wire       clk_in,
    input wire       rst_n_in,
    input wire       charge_hold_in,
    input wire       cell_above_max_in,
    input wire       cell_above_pd_in,
    input wire       charge_switch_oe_out,
    input wire       status_indicator_oe_out,
    input wire [2:0] charge_state_out
);
    logic [4:0]  hh_ff, hp_ff, hm_ff;
    logic [2:0]  up_ff;
    logic [12:0] run_ff;
    wire [2:0]   st = charge_state_out;
    wire         quiet = ~|hh_ff && !charge_hold_in;
    wire         ready = up_ff == 3'h7;
    // input history, cycles since reset, length of a current pulse
    always @(posedge clk_in) begin
        hh_ff <= {hh_ff[3:0], charge_hold_in};
        hp_ff <= {hp_ff[3:0], cell_above_pd_in};
        hm_ff <= {hm_ff[3:0], cell_above_max_in};
        up_ff <= !rst_n_in ? 3'h0 : up_ff + {2'h0, !ready};
        run_ff <= (!rst_n_in || charge_switch_oe_out || st < `BCS_ST_TOPOFF
                   || st == `BCS_ST_LOWPWR) ? 13'h0000 : run_ff + 13'h0001;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    lowpwr_pins_a: assert property (
        st == `BCS_ST_LOWPWR |-> !charge_switch_oe_out && !status_indicator_oe_out)
        else $error("pin driven in low power");
    pd_enter_a: assert property (
        ready && &hp_ff && cell_above_pd_in |-> st == `BCS_ST_LOWPWR)
        else $error("no low power above threshold");
    max_end_a: assert property (
        ready && &hm_ff && cell_above_max_in |-> st != `BCS_ST_FAST && st != `BCS_ST_TOPOFF)
        else $error("charging above max voltage");
    fast_switch_a: assert property (
        st == `BCS_ST_FAST && quiet |-> !charge_switch_oe_out)
        else $error("current blocked in fast charge");
    lamp_on_a: assert property (
        (st == `BCS_ST_FAST || st == `BCS_ST_PEND) && quiet |-> status_indicator_oe_out)
        else $error("indicator dark while charging");
    lamp_off_a: assert property (
        st > `BCS_ST_FAST && quiet |-> !status_indicator_oe_out)
        else $error("indicator lit after charging");
    hold_lamp_a: assert property (
        ready && &hh_ff && charge_hold_in && st != `BCS_ST_LOWPWR
        && $past(st) != `BCS_ST_LOWPWR |-> $stable(status_indicator_oe_out))
        else $error("indicator moved during hold");
    pulse_len_a: assert property (
        run_ff <= 13'h0B2C) else $error("current pulse too long");
endmodule // bcs_seq_assertions
bind bcs_charge_sequencer bcs_seq_assertions u_bcs_seq_assertions (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .charge_hold_in(charge_hold_in),
    .cell_above_max_in(cell_above_max_in), .cell_above_pd_in(cell_above_pd_in),
    .charge_switch_oe_out(charge_switch_oe_out),
    .status_indicator_oe_out(status_indicator_oe_out), .charge_state_out(charge_state_out));
`default_nettype wire
